// ### verilog/tlb_address_translation.sv
// Two-way 32-line translation buffer with AHB-Lite register access.
// Assumes requests come from fetch/load-store logic on hclk; results one cycle later.
`default_nettype none
module tlb_address_translation
  import tlb_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Access request
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_instr,
  input wire logic req_supervisor,
  input wire logic req_store,
  input wire logic req_mem_space,
  input wire logic instr_physical_flag,
  input wire logic req_offset_step,
  // Channel address cycle
  output logic addr_valid,
  output logic [31:0] phys_addr,
  output logic io_space,
  output logic translated,
  output logic [1:0] user_prog_outputs,
  output logic bus_invalid,
  // Trap
  output logic trap_valid,
  output logic [3:0] trap_vector
);
  tlb_entry_if ent ();

  // Register state
  logic [7:0] process_number_ff;
  logic [1:0] page_size_ff;
  logic phys_instr_addressing_ff;
  logic rom_select_ff;
  logic phys_data_addressing_ff;
  logic [6:0] entry_sel_ff;
  logic [6:0] replace_ff;
  logic [31:0] pc1_ff;
  logic [31:0] chan_addr_ff;
  logic [3:0] last_trap_ff;
  logic [LINES-1:0] lru_ff;

  // Bus pipeline state
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] bus_addr_ff;

  // Channel output state
  logic addr_valid_ff;
  logic [31:0] phys_addr_ff;
  logic io_space_ff;
  logic translated_ff;
  logic [1:0] prog_ff;
  logic bus_invalid_ff;
  logic trap_valid_ff;
  logic [3:0] trap_vector_ff;

  // ---------------- Bus decode ----------------
  // Zero wait states: every transfer completes in its first data cycle
  wire bus_take = hsel && (htrans == HTRANS_NONSEQ) && hready;
  wire wr_config = wr_pend_ff && (bus_addr_ff == OFS_CONFIG);
  wire wr_control = wr_pend_ff && (bus_addr_ff == OFS_CONTROL);
  wire wr_sel = wr_pend_ff && (bus_addr_ff == OFS_ENTRY_SEL);
  wire wr_entry = wr_pend_ff && (bus_addr_ff == OFS_ENTRY_DATA);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      bus_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= bus_take && hwrite;
      rd_pend_ff <= bus_take && !hwrite;
      bus_addr_ff <= bus_take ? {haddr[7:2], 2'b00} : bus_addr_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      process_number_ff <= CONFIG_RESET[7:0];
      page_size_ff <= CONFIG_RESET[9:8];
    end else if (wr_config) begin
      process_number_ff <= hwdata[7:0];
      page_size_ff <= hwdata[9:8];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phys_instr_addressing_ff <= CONTROL_RESET[CTL_PHYS_INSTR];
      rom_select_ff <= CONTROL_RESET[CTL_ROM_SELECT];
      phys_data_addressing_ff <= CONTROL_RESET[CTL_PHYS_DATA];
    end else if (wr_control) begin
      phys_instr_addressing_ff <= hwdata[CTL_PHYS_INSTR];
      rom_select_ff <= hwdata[CTL_ROM_SELECT];
      phys_data_addressing_ff <= hwdata[CTL_PHYS_DATA];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_sel_ff <= 7'h00;
    end else if (wr_sel) begin
      entry_sel_ff <= hwdata[6:0];
    end
  end

  // Entry store port: writes through the data window go to the selected register
  assign ent.wr_en = wr_entry;
  assign ent.wr_idx = entry_sel_ff;
  assign ent.wr_data = hwdata;
  assign ent.rd_idx = entry_sel_ff;

  // The usage bit lives per line; word 1 of either set shows the same copy
  wire sel_is_w1 = entry_sel_ff[0];
  wire [4:0] sel_line = entry_sel_ff[5:1];
  wire [31:0] entry_read = sel_is_w1 ?
      {ent.rd_data[31:W1_USAGE+1], lru_ff[sel_line], ent.rd_data[W1_USAGE-1:0]} :
      ent.rd_data;

  wire [31:0] rd_mux =
      (bus_addr_ff == OFS_CONFIG) ? {22'h00_0000, page_size_ff, process_number_ff} :
      (bus_addr_ff == OFS_CONTROL) ? {29'h0000_0000, phys_data_addressing_ff,
                                     rom_select_ff, phys_instr_addressing_ff} :
      (bus_addr_ff == OFS_ENTRY_SEL) ? {25'h000_0000, entry_sel_ff} :
      (bus_addr_ff == OFS_ENTRY_DATA) ? entry_read :
      (bus_addr_ff == OFS_REPLACE) ? {25'h000_0000, replace_ff} :
      (bus_addr_ff == OFS_PC1) ? pc1_ff :
      (bus_addr_ff == OFS_CHAN_ADDR) ? chan_addr_ff :
      (bus_addr_ff == OFS_TRAP) ? {28'h000_0000, last_trap_ff} :
      32'h0000_0000;

  assign hrdata = rd_pend_ff ? rd_mux : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ---------------- Translation decision ----------------
  wire xlate_instr = req_instr && !phys_instr_addressing_ff && !rom_select_ff;
  wire xlate_user = !req_supervisor && !phys_data_addressing_ff;
  wire xlate_sup = req_supervisor && !instr_physical_flag && !phys_data_addressing_ff;
  wire xlate_data = !req_instr && req_mem_space && (xlate_user || xlate_sup);
  wire do_xlate = xlate_instr || xlate_data;

  // ---------------- Lookup ----------------
  wire [31:0] line_shifted = req_addr >> (PAGE_SHIFT_MIN + 32'(page_size_ff));
  assign ent.line = line_shifted[4:0];
  wire [4:0] cur_line = line_shifted[4:0];

  wire [16:0] tag_mask = TAG_MASK_ALL << page_size_ff;
  wire [31:0] off_mask = ~(ALL_ONES << (PAGE_SHIFT_MIN + 32'(page_size_ff)));
  wire [7:0] want_task = req_supervisor ? 8'h00 : process_number_ff;

  wire [31:0] w0 [2];
  wire [31:0] w1 [2];
  wire [1:0] match;
  wire [1:0] allowed;
  assign w0[0] = ent.s0_w0;
  assign w0[1] = ent.s1_w0;
  assign w1[0] = ent.s0_w1;
  assign w1[1] = ent.s1_w1;

  for (genvar s = 0; s < 2; s++) begin : g_set
    wire [16:0] tag_diff = (w0[s][31:W0_TAG_LSB] ^ req_addr[31:W0_TAG_LSB]) & tag_mask;
    wire task_ok = (w0[s][7:0] == want_task);
    assign match[s] = (tag_diff == 17'h0_0000) && task_ok && w0[s][W0_VALID];

    tlb_protect u_prot (
      .prot(w0[s][W0_PROT_LSB+5:W0_PROT_LSB]),
      .supervisor(req_supervisor),
      .instr(req_instr),
      .store(req_store),
      .allowed(allowed[s])
    );
  end

  // Two matches are undefined; set 0 is preferred so the result is at least stable
  wire hit = |match;
  wire hit_set = !match[0];
  wire [31:0] hit_w1 = w1[hit_set];
  wire hit_allowed = allowed[hit_set];

  wire [31:0] offset = req_offset_step ? (req_addr + FETCH_STEP) : req_addr;
  wire [31:0] rpn_base = {hit_w1[31:W1_RPN_LSB], 10'h000};
  wire [31:0] xlate_addr = (rpn_base & ~off_mask) | (offset & off_mask);

  wire go_xlate = req_valid && do_xlate;
  wire miss = go_xlate && !hit;
  wire prot_fail = go_xlate && hit && !hit_allowed;
  wire ok_xlate = go_xlate && hit && hit_allowed;
  wire any_trap = miss || prot_fail;

  wire [3:0] miss_vec = req_supervisor ?
      (req_instr ? VEC_SUP_INSTR_MISS : VEC_SUP_DATA_MISS) :
      (req_instr ? VEC_USER_INSTR_MISS : VEC_USER_DATA_MISS);
  wire [3:0] prot_vec = req_instr ? VEC_INSTR_PROT : VEC_DATA_PROT;
  wire [3:0] nxt_trap_vector = miss ? miss_vec : prot_vec;

  wire victim_set = lru_ff[cur_line];
  wire [6:0] nxt_replace = {victim_set, cur_line, 1'b0};

  // ---------------- Usage bits ----------------
  // A software write to word 1 loads the usage copy and overrides a same-cycle hit
  wire sw_usage_wr = wr_entry && sel_is_w1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lru_ff <= '0;
    end else if (sw_usage_wr) begin
      lru_ff[sel_line] <= hwdata[W1_USAGE];
    end else if (ok_xlate) begin
      lru_ff[cur_line] <= !hit_set;
    end
  end

  // ---------------- Reload hints ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      replace_ff <= 7'h00;
    end else if (miss) begin
      replace_ff <= nxt_replace;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc1_ff <= 32'h0000_0000;
    end else if (any_trap && req_instr) begin
      pc1_ff <= req_addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_addr_ff <= 32'h0000_0000;
    end else if (any_trap && !req_instr) begin
      chan_addr_ff <= req_addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_trap_ff <= 4'h0;
    end else if (any_trap) begin
      last_trap_ff <= nxt_trap_vector;
    end
  end

  // ---------------- Address cycle outputs ----------------
  // A trapping access is still shown, flagged invalid, so the channel sees a complete cycle
  wire [31:0] nxt_phys_addr = ok_xlate ? xlate_addr : req_addr;
  wire nxt_io_space = ok_xlate && hit_w1[W1_IO];
  wire [1:0] nxt_prog = ok_xlate ? hit_w1[W1_PROG_LSB+1:W1_PROG_LSB] : 2'b00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_valid_ff <= 1'b0;
      phys_addr_ff <= 32'h0000_0000;
      io_space_ff <= 1'b0;
      translated_ff <= 1'b0;
      prog_ff <= 2'b00;
      bus_invalid_ff <= 1'b0;
    end else begin
      addr_valid_ff <= req_valid;
      phys_addr_ff <= nxt_phys_addr;
      io_space_ff <= nxt_io_space;
      translated_ff <= ok_xlate;
      prog_ff <= nxt_prog;
      bus_invalid_ff <= any_trap;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap_valid_ff <= 1'b0;
      trap_vector_ff <= 4'h0;
    end else begin
      trap_valid_ff <= any_trap;
      trap_vector_ff <= any_trap ? nxt_trap_vector : 4'h0;
    end
  end

  assign addr_valid = addr_valid_ff;
  assign phys_addr = phys_addr_ff;
  assign io_space = io_space_ff;
  assign translated = translated_ff;
  assign user_prog_outputs = prog_ff;
  assign bus_invalid = bus_invalid_ff;
  assign trap_valid = trap_valid_ff;
  assign trap_vector = trap_vector_ff;

  tlb_entry_store u_store (
    .hclk(hclk),
    .hresetn(hresetn),
    .ent(ent)
  );

  // hsize is accepted but not checked: only whole-word transfers are expected
  wire unused_ok = &{1'b0, hsize, haddr[31:8], haddr[1:0]};
endmodule // tlb_address_translation
`default_nettype wire

// ### inc/tlb_pkg.sv
// Constants, register map and entry layout of the address translation unit.
// Assumes a single 100 MHz clock and software access over an AHB-Lite slave.
`default_nettype none
package tlb_pkg;
  localparam int unsigned LINES = 32;
  localparam int unsigned ENTRY_REGS = 128;
  localparam int unsigned PAGE_SHIFT_MIN = 10;
  localparam logic [16:0] TAG_MASK_ALL = 17'h1_ffff;
  localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
  localparam logic [31:0] FETCH_STEP = 32'h0000_0010;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_ENTRY_SEL = 8'h08;
  localparam logic [7:0] OFS_ENTRY_DATA = 8'h0c;
  localparam logic [7:0] OFS_REPLACE = 8'h10;
  localparam logic [7:0] OFS_PC1 = 8'h14;
  localparam logic [7:0] OFS_CHAN_ADDR = 8'h18;
  localparam logic [7:0] OFS_TRAP = 8'h1c;
  // Reset values; physical addressing after reset keeps the empty table out of the path
  localparam logic [9:0] CONFIG_RESET = 10'h000;
  localparam logic [2:0] CONTROL_RESET = 3'h7;
  // Control register bit positions
  localparam int unsigned CTL_PHYS_INSTR = 0;
  localparam int unsigned CTL_ROM_SELECT = 1;
  localparam int unsigned CTL_PHYS_DATA = 2;
  // Entry word 0 field positions
  localparam int unsigned W0_TAG_LSB = 15;
  localparam int unsigned W0_VALID = 14;
  localparam int unsigned W0_PROT_LSB = 8;
  // Entry word 1 field positions
  localparam int unsigned W1_RPN_LSB = 10;
  localparam int unsigned W1_PROG_LSB = 6;
  localparam int unsigned W1_USAGE = 1;
  localparam int unsigned W1_IO = 0;
  // Trap vectors
  localparam logic [3:0] VEC_USER_INSTR_MISS = 4'h8;
  localparam logic [3:0] VEC_USER_DATA_MISS = 4'h9;
  localparam logic [3:0] VEC_SUP_INSTR_MISS = 4'ha;
  localparam logic [3:0] VEC_SUP_DATA_MISS = 4'hb;
  localparam logic [3:0] VEC_INSTR_PROT = 4'hc;
  localparam logic [3:0] VEC_DATA_PROT = 4'hd;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage
`default_nettype wire

// ### inc/tlb_entry_if.sv
// Bundle between the translation core and its entry store.
// Assumes both ends run on hclk.
`default_nettype none
interface tlb_entry_if;
  logic wr_en;
  logic [6:0] wr_idx;
  logic [31:0] wr_data;
  logic [6:0] rd_idx;
  logic [31:0] rd_data;
  logic [4:0] line;
  logic [31:0] s0_w0;
  logic [31:0] s0_w1;
  logic [31:0] s1_w0;
  logic [31:0] s1_w1;
  modport store (input wr_en, wr_idx, wr_data, rd_idx, line,
                 output rd_data, s0_w0, s0_w1, s1_w0, s1_w1);
  modport core (output wr_en, wr_idx, wr_data, rd_idx, line,
                input rd_data, s0_w0, s0_w1, s1_w0, s1_w1);
endinterface
`default_nettype wire

// ### verilog/tlb_entry_store.sv
// Entry store: 128 registers of 32 bits, number = {set, line, word}.
// Assumes one write per cycle; reads are combinational.
`default_nettype none
module tlb_entry_store
  import tlb_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Core side
  tlb_entry_if.store ent
);
  logic [31:0] mem_ff [0:ENTRY_REGS-1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < ENTRY_REGS; i++) begin
        mem_ff[i] <= 32'h0000_0000;
      end
    end else if (ent.wr_en) begin
      mem_ff[ent.wr_idx] <= ent.wr_data;
    end
  end

  // Both sets of the addressed line are read at once
  assign ent.s0_w0 = mem_ff[{1'b0, ent.line, 1'b0}];
  assign ent.s0_w1 = mem_ff[{1'b0, ent.line, 1'b1}];
  assign ent.s1_w0 = mem_ff[{1'b1, ent.line, 1'b0}];
  assign ent.s1_w1 = mem_ff[{1'b1, ent.line, 1'b1}];
  assign ent.rd_data = mem_ff[ent.rd_idx];
endmodule // tlb_entry_store
`default_nettype wire

// ### verilog/tlb_protect.sv
// Access permission decode from the six protection bits of an entry.
// Assumes prot = {sup read, sup write, sup exec, user read, user write, user exec}.
`default_nettype none
module tlb_protect (
  // Entry bits
  input wire logic [5:0] prot,
  // Access kind
  input wire logic supervisor,
  input wire logic instr,
  input wire logic store,
  // Result
  output logic allowed
);
  wire [2:0] rwx = supervisor ? prot[5:3] : prot[2:0];
  wire want_load = !instr && !store;
  wire want_store = !instr && store;
  assign allowed = (want_load && rwx[2]) || (want_store && rwx[1]) || (instr && rwx[0]);
endmodule // tlb_protect
`default_nettype wire

// ### sim/tlb_address_translation_monitor.sv
// Property checker for the request and answer ports of the translation unit.
// Assumes it is bound to the top module and sees its ports only.
`default_nettype none
module tlb_address_translation_monitor (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus response
  input wire logic hreadyout,
  input wire logic hresp,
  // Request
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_instr,
  input wire logic req_supervisor,
  input wire logic req_offset_step,
  // Answer
  input wire logic addr_valid,
  input wire logic [31:0] phys_addr,
  input wire logic io_space,
  input wire logic translated,
  input wire logic [1:0] user_prog_outputs,
  input wire logic bus_invalid,
  input wire logic trap_valid,
  input wire logic [3:0] trap_vector
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [9:0] nxt_off;
  // Offset bits below 1 kb survive every page size, even after the 16 step wraps
  assign nxt_off = req_addr[9:0] + (req_offset_step ? 10'h010 : 10'h000);
  sequence s_issued(cond);
    req_valid && cond;
  endsequence
  a_answer_next: assert property (s_issued(1'b1) |=> addr_valid)
    else $error("no address cycle after request");
  a_no_stray: assert property (!req_valid |=> !addr_valid && !trap_valid)
    else $error("answer without request");
  a_trap_marks: assert property (addr_valid |-> trap_valid == bus_invalid)
    else $error("bus invalid disagrees with trap");
  a_trap_range: assert property (trap_valid |-> addr_valid && trap_vector inside {[8:13]})
    else $error("trap vector out of range");
  a_trap_quiet: assert property (trap_valid |-> !translated && user_prog_outputs == 2'b00)
    else $error("trapping access shows translation");
  a_prog_low: assert property (addr_valid && !translated |-> user_prog_outputs == 2'b00 && !io_space)
    else $error("outputs not low when untranslated");
  a_raw_pass: assert property (s_issued(1'b1) ##1 !translated |-> phys_addr == $past(req_addr))
    else $error("untranslated address altered");
  a_offset_kept: assert property (s_issued(1'b1) ##1 translated |-> phys_addr[9:0] == $past(nxt_off))
    else $error("page offset not carried");
  a_instr_vector: assert property (s_issued(req_instr) ##1 trap_valid |-> trap_vector inside {8, 10, 12})
    else $error("instruction trap vector wrong");
  a_sup_data_vec: assert property (s_issued(req_supervisor && !req_instr) ##1 trap_valid |-> trap_vector inside {11, 13})
    else $error("supervisor data trap vector wrong");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not ready okay");
endmodule // tlb_address_translation_monitor
bind tlb_address_translation tlb_address_translation_monitor mon (.hclk, .hresetn, .hreadyout,
  .hresp, .req_valid, .req_addr, .req_instr, .req_supervisor, .req_offset_step, .addr_valid,
  .phys_addr, .io_space, .translated, .user_prog_outputs, .bus_invalid, .trap_valid, .trap_vector);
`default_nettype wire

// ### sim/access_source.sv
// Stand-in for the fetch and load/store units issuing virtual addresses.
// Assumes the translator takes one request per clock with no back-pressure.
`default_nettype none
module access_source (
  // Clock
  input wire logic hclk,
  // Request
  output logic req_valid,
  output logic [31:0] req_addr,
  output logic req_instr,
  output logic req_supervisor,
  output logic req_store,
  output logic req_mem_space,
  output logic instr_physical_flag,
  output logic req_offset_step
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {req_valid, req_addr, req_instr, req_supervisor} = '0;
    {req_store, req_mem_space, instr_physical_flag, req_offset_step} = '0;
  end
  // k = {instr, supervisor, store, memory space, physical flag, offset step}
  task automatic issue(input logic [31:0] va, input logic [5:0] k);
    @(posedge hclk);
    req_valid <= 1'b1;
    req_addr <= va;
    {req_instr, req_supervisor, req_store, req_mem_space, instr_physical_flag, req_offset_step} <= k;
    @(posedge hclk);
    req_valid <= 1'b0;
    // Released address lines do not keep the old value
    req_addr <= ~va;
  endtask
endmodule // access_source
`default_nettype wire

// ### sim/tlb_address_translation_tb.sv
// Self-checking bench: random entries and accesses against a bench model.
// Assumes one-cycle answers and a zero-wait AHB-Lite slave.
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tlb_address_translation_tb
  import tlb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic req_valid, req_instr, req_supervisor, req_store, req_mem_space;
  logic instr_physical_flag, req_offset_step, addr_valid, io_space, translated;
  logic bus_invalid, trap_valid;
  logic [31:0] haddr, hwdata, hrdata, req_addr, phys_addr;
  logic [1:0] htrans, user_prog_outputs;
  logic [2:0] hsize;
  logic [3:0] trap_vector;
  int miscompares, num_checks, cyc, sz, ln;
  logic [31:0] ent [128];
  logic lru [32];
  logic [31:0] cfg, ctl, rep, pc1, chan, trp, rng, v, rn, va, m, rd, d0;
  logic [31:0] vq [6];
  logic [5:0] k;
  logic [42:0] want;
  assign hready = hreadyout;
  tlb_address_translation dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .req_valid, .req_addr, .req_instr,
    .req_supervisor, .req_store, .req_mem_space, .instr_physical_flag, .req_offset_step,
    .addr_valid, .phys_addr, .io_space, .translated, .user_prog_outputs, .bus_invalid,
    .trap_valid, .trap_vector);
  access_source src (.hclk, .req_valid, .req_addr, .req_instr, .req_supervisor, .req_store,
    .req_mem_space, .instr_physical_flag, .req_offset_step);
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic put(input logic [6:0] idx, input logic [31:0] d);
    ahb(1'b1, OFS_ENTRY_SEL, {25'h0, idx}, rd);
    ahb(1'b1, OFS_ENTRY_DATA, d, rd);
    ahb(1'b0, OFS_ENTRY_DATA, 32'h0000_0000, rd);
    `CHK(rd, d)
    ent[idx] = d;
    if (idx[0]) lru[idx[5:1]] = d[1];
  endtask
  // Bench model of one lookup; fills want and the trap-side registers
  task automatic model(input logic [31:0] va, input logic [5:0] k);
    int s_hit, ln, b;
    logic [31:0] w0, w1, m;
    logic tr;
    m = (32'h0000_0001 << (10 + cfg[9:8])) - 1;
    ln = (va >> (10 + cfg[9:8])) & 31;
    tr = k[5] ? ctl[1:0] == 2'h0 : k[2] && !ctl[2] && (!k[4] || !k[1]);
    want = {11'h400, va};
    if (!tr) return;
    s_hit = -1;
    for (int s = 1; s >= 0; s--) begin
      w0 = ent[s * 64 + ln * 2];
      if (((w0 ^ va) >> (15 + cfg[9:8])) == 0 && w0[14] && w0[7:0] == (k[4] ? 8'h00 : cfg[7:0])) s_hit = s;
    end
    if (s_hit < 0) begin
      want[35:32] = k[5] ? (k[4] ? VEC_SUP_INSTR_MISS : VEC_USER_INSTR_MISS) : (k[4] ? VEC_SUP_DATA_MISS : VEC_USER_DATA_MISS);
      rep = {25'h0, lru[ln], ln[4:0], 1'b0};
    end else begin
      w0 = ent[s_hit * 64 + ln * 2];
      w1 = ent[s_hit * 64 + ln * 2 + 1];
      b = (k[4] ? 3 : 0) + (k[5] ? 0 : (k[3] ? 1 : 2));
      if (!w0[8 + b]) begin
        want[35:32] = k[5] ? VEC_INSTR_PROT : VEC_DATA_PROT;
      end else begin
        lru[ln] = !s_hit[0];
        want = {2'h3, w1[0], w1[7:6], 6'h00, (w1 & ~m) | ((va + (k[0] ? FETCH_STEP : 32'h0000_0000)) & m)};
      end
    end
    if (want[35:32] != 4'h0) begin
      want[37:36] = 2'h3;
      trp = {28'h0, want[35:32]};
      if (k[5]) pc1 = va; else chan = va;
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, miscompares, num_checks, cyc} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    rng = 32'h0000_004c;
    cfg = 32'h0000_0000;
    ctl = 32'h0000_0007;
    // Reload hints read back after a protection trap may predate any miss
    {rep, pc1, chan, trp} = '0;
    for (int i = 0; i < 128; i++) ent[i] = 32'h0000_0000;
    for (int i = 0; i < 32; i++) lru[i] = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFS_CONTROL, 32'h0000_0000, rd);
    `CHK(rd, ctl)
    ahb(1'b0, 8'h80, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    for (int r = 0; r < 8; r++) begin
      rn = rnd();
      cfg = {22'h0, r[1:0], rn[7:1], 1'b1};
      ctl = (r == 1 || r == 6) ? {29'h0, rn[10:8]} : 32'h0000_0000;
      ahb(1'b1, OFS_CONFIG, cfg, rd);
      ahb(1'b1, OFS_CONTROL, ctl, rd);
      ahb(1'b0, OFS_CONFIG, 32'h0000_0000, rd);
      `CHK(rd, cfg)
      sz = r % 4;
      m = (32'h0000_0001 << (10 + sz)) - 1;
      for (int e = 0; e < 6; e++) begin
        v = rnd();
        rn = rnd();
        vq[e] = v;
        ln = (v >> (10 + sz)) & 31;
        // Tag bits below the compared range stay zero for large pages
        d0 = (v & ~((m << 5) | 32'h0000_7fff)) |
            {17'h0, |rn[2:0], rn[13:8] | rn[21:16], rn[3] ? 8'h00 : cfg[7:0]};
        // Bits 31-18 take part at every page size, so distinct ones keep one match per line
        if (ent[{~rn[4], ln[4:0], 1'b0}][31:18] == d0[31:18] &&
            ent[{~rn[4], ln[4:0], 1'b0}][7:0] == d0[7:0]) begin
          d0[14] = 1'b0;
        end
        put({rn[4], ln[4:0], 1'b0}, d0);
        put({rn[4], ln[4:0], 1'b1}, rnd());
      end
      repeat (30) begin
        rn = rnd();
        va = (rn[3:0] == 4'h0) ? rnd() : vq[rn[6:4] % 6] ^ (rnd() & m);
        k = rn[13:8] | {3'h0, rn[14], 2'h0};
        src.issue(va, k);
        model(va, k);
        #1;
        `CHK({addr_valid, translated, io_space, user_prog_outputs, bus_invalid, trap_valid, trap_vector, phys_addr}, want)
        if (want[36]) begin
          ahb(1'b0, OFS_TRAP, 32'h0000_0000, rd);
          `CHK(rd, trp)
          ahb(1'b0, OFS_REPLACE, 32'h0000_0000, rd);
          `CHK(rd, rep)
          ahb(1'b0, k[5] ? OFS_PC1 : OFS_CHAN_ADDR, 32'h0000_0000, rd);
          `CHK(rd, k[5] ? pc1 : chan)
        end
      end
    end
    end_sim();
  end
endmodule // tlb_address_translation_tb
`default_nettype wire
